/* File: core/otps_defs.svh */
// Purpose: Constants for the output test pulse sequencer
// Assumes: core_clk at 40 MHz; logic tick marks one internal logic cycle
// Notes:   Long cycle counts are also top-level parameters
`ifndef OTPS_DEFS_SVH
`define OTPS_DEFS_SVH
// ==========================================================
// Timing
`define OTPS_CLK_MHZ 40
`define OTPS_BASE_PULSE_US 400
`define OTPS_MIN_LOW_US 200
`define OTPS_BASE_PULSE_CYC (`OTPS_BASE_PULSE_US * `OTPS_CLK_MHZ)
`define OTPS_MIN_LOW_CYC (`OTPS_MIN_LOW_US * `OTPS_CLK_MHZ)
// ==========================================================
// Schedule figures, in logic cycles; the interval scales them to quarters (1.25 = 5/4)
`define OTPS_FEEDBACK_CYCLES 4
`define OTPS_DIAG_CYCLES 4
`define OTPS_OUTPUTS 4
`define OTPS_OUT_MODULES 6
`define OTPS_RELAY_CYCLES 100
`define OTPS_IN_MODULES 10
`define OTPS_SCALE_Q 5
`define OTPS_QUARTERS 4
// ==========================================================
// Defaults and error counter
`define OTPS_FACTOR_DEFAULT 4'h2
`define OTPS_ERR_WEIGHT 8'h04
`define OTPS_ERR_THRESHOLD 8'h10
`endif

/* File: core/otps_pkg.sv */
// Purpose: Types shared by the output test pulse sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Step index: bit 0 set means module switch test
package otps_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PULSE,
    SEQ_GAP
  } otps_state_t;
  typedef logic [2:0] otps_step_t;
endpackage

/* File: core/otps_pulse_timer.sv */
// Purpose: One-shot timer that holds busy for a loaded number of cycles
// Assumes: start is only raised while not busy
// Notes:   done marks the last busy cycle
module otps_pulse_timer #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] lenCycles,
  // Status
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  // Load on start, count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = lenCycles;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = (cnt_reg == WIDTH'(1));
endmodule

/* File: core/otps_sequencer.sv */
// Purpose: Test pulse scheduler for a group of four safe outputs
// Assumes: logicTick is one pulse per internal logic cycle
// Notes:   Diagnostic verdicts come from the readback logic outside
`include "otps_defs.svh"
module otps_sequencer #(
  parameter int BASE_PULSE_CYC = `OTPS_BASE_PULSE_CYC,
  parameter int MIN_LOW_CYC = `OTPS_MIN_LOW_CYC,
  parameter int LEN_W = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic configLoad,
  input wire logic factorWrite,
  input wire logic [3:0] pulseLengthFactor,
  input wire logic [7:0] diagRepeatModulo,
  input wire logic pulseTestEnable,
  input wire logic inputClockMode,
  // Timing and application
  input wire logic logicTick,
  input wire logic [3:0] outRequest,
  // Diagnostic verdicts
  input wire logic diagDone,
  input wire logic diagFail,
  input wire logic violationEvent,
  input wire logic memTestFail,
  // Outputs and status
  output logic [3:0] outDrive,
  output logic [3:0] factorOut,
  output otps_pkg::otps_step_t testStep,
  output logic testActive,
  output logic switchOff,
  output logic [7:0] errorCount,
  output logic [15:0] violationCount
);
  import otps_pkg::*;

  // ==========================================================
  // Declarations
  otps_state_t state_reg, state_next;
  otps_step_t step_reg, step_next;
  logic [3:0] factor_reg, factor_next;
  logic [19:0] gapQ_reg, gapQ_next;
  logic [7:0] err_reg, err_next;
  logic off_reg, off_next;
  logic [15:0] viol_reg, viol_next;
  logic [3:0] drive_reg, drive_next;
  logic startPulse, timerBusy, timerDone;
  logic [LEN_W-1:0] pulseLen;
  logic [LEN_W-1:0] factorProd;
  logic [19:0] modQ, intervalQ;
  logic [3:0] pulseMask;

  // ==========================================================
  // Pulse length: factor times base, never below the low floor
  assign factorProd = LEN_W'(factor_reg) * LEN_W'(BASE_PULSE_CYC);
  assign pulseLen = (factorProd < LEN_W'(MIN_LOW_CYC)) ?
                    LEN_W'(MIN_LOW_CYC) : factorProd;

  otps_pulse_timer #(.WIDTH(LEN_W)) u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(startPulse),
    .lenCycles(pulseLen),
    .busy(timerBusy),
    .done(timerDone)
  );

  // ==========================================================
  // Interval b in quarter logic cycles, so 1.25 stays exact
  assign modQ = 20'((`OTPS_FEEDBACK_CYCLES + `OTPS_DIAG_CYCLES *
                (diagRepeatModulo + 9'h001)) * `OTPS_SCALE_Q *
                `OTPS_OUTPUTS);
  assign intervalQ = 20'(`OTPS_OUT_MODULES * modQ +
                     `OTPS_RELAY_CYCLES * `OTPS_SCALE_Q +
                     `OTPS_IN_MODULES * `OTPS_SCALE_Q);

  // ==========================================================
  // Factor register: defaults load wins over a software write
  always_comb begin
    factor_next = factor_reg;
    if (configLoad) begin
      factor_next = `OTPS_FACTOR_DEFAULT;
    end else if (factorWrite) begin
      factor_next = pulseLengthFactor;
    end
  end

  // ==========================================================
  // Schedule: pulse, then wait b, then next step
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    gapQ_next = gapQ_reg;
    startPulse = 1'b0;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (pulseTestEnable) begin
          startPulse = 1'b1;
          state_next = SEQ_PULSE;
        end
      end
      SEQ_PULSE: begin
        if (timerDone) begin
          gapQ_next = '0;
          state_next = SEQ_GAP;
        end
      end
      SEQ_GAP: begin
        if (!pulseTestEnable) begin
          state_next = SEQ_IDLE;
        end else if (gapQ_reg >= intervalQ) begin
          if (inputClockMode) begin
            step_next = {step_reg[2:1] + 2'h1, 1'b0};
          end else begin
            step_next = step_reg + 3'h1;
          end
          startPulse = 1'b1;
          state_next = SEQ_PULSE;
        end else if (logicTick) begin
          gapQ_next = gapQ_reg + 20'(`OTPS_QUARTERS);
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  // Which outputs the running pulse pulls low
  always_comb begin
    pulseMask = 4'h0;
    if (timerBusy) begin
      if (step_reg[0] && !inputClockMode) begin
        pulseMask = 4'hF;
      end else begin
        pulseMask = 4'h1 << step_reg[2:1];
      end
    end
  end

  // Output drive; with pulseTestEnable set, input-clock mode holds all outputs on between pulses
  always_comb begin
    if (off_reg) begin
      drive_next = 4'h0;
    end else if (inputClockMode && pulseTestEnable) begin
      drive_next = ~pulseMask;
    end else begin
      drive_next = outRequest & ~pulseMask;
    end
  end

  // ==========================================================
  // Weighted error counter; a trip stays until reset
  always_comb begin
    err_next = err_reg;
    off_next = off_reg;
    viol_next = viol_reg;
    if (diagDone && diagFail) begin
      err_next = (err_reg > 8'hFF - `OTPS_ERR_WEIGHT) ? 8'hFF :
                 err_reg + `OTPS_ERR_WEIGHT;
    end else if (diagDone && err_reg != 8'h00) begin
      err_next = err_reg - 8'h01;
    end
    if (err_reg >= `OTPS_ERR_THRESHOLD || memTestFail) begin
      off_next = 1'b1;
    end
    if (violationEvent && viol_reg != 16'hFFFF) begin
      viol_next = viol_reg + 16'h0001;
    end
  end

  // Registers; factor resets to the configuration default
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SEQ_IDLE;
      step_reg <= 3'h0;
      gapQ_reg <= 20'h00000;
      factor_reg <= `OTPS_FACTOR_DEFAULT;
      err_reg <= 8'h00;
      off_reg <= 1'b0;
      viol_reg <= 16'h0000;
      drive_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      gapQ_reg <= gapQ_next;
      factor_reg <= factor_next;
      err_reg <= err_next;
      off_reg <= off_next;
      viol_reg <= viol_next;
      drive_reg <= drive_next;
    end
  end

  assign outDrive = drive_reg;
  assign factorOut = factor_reg;
  assign testStep = step_reg;
  assign testActive = timerBusy;
  assign switchOff = off_reg;
  assign errorCount = err_reg;
  assign violationCount = viol_reg;

  // ==========================================================
  // Checks; pulseAge counts cycles of the running pulse
  logic [LEN_W-1:0] pulseAge;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseAge <= '0;
    end else begin
      pulseAge <= timerBusy ? pulseAge + LEN_W'(1) : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_factor_default;
    configLoad |=> factor_reg == `OTPS_FACTOR_DEFAULT;
  endproperty
  a_factor_default: assert property (p_factor_default)
    else $error("factor not 2 after defaults load");

  property p_enable_needed;
    $rose(timerBusy) |-> $past(pulseTestEnable);
  endproperty
  a_enable_needed: assert property (p_enable_needed)
    else $error("pulse started while testing disabled");

  property p_pulse_len;
    $fell(timerBusy) |-> $past(pulseAge) + LEN_W'(1) == $past(pulseLen);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse length differs from factor times base");

  property p_min_low;
    $fell(timerBusy) |-> $past(pulseAge) + LEN_W'(1) >= LEN_W'(MIN_LOW_CYC);
  endproperty
  a_min_low: assert property (p_min_low)
    else $error("pulse shorter than the low floor");

  property p_order;
    (startPulse && state_reg == SEQ_GAP && !inputClockMode)
      |=> step_reg == $past(step_reg) + 3'h1;
  endproperty
  a_order: assert property (p_order)
    else $error("channel and switch tests out of order");

  property p_icm_no_switch;
    (startPulse && state_reg == SEQ_GAP && inputClockMode)
      |=> !step_reg[0];
  endproperty
  a_icm_no_switch: assert property (p_icm_no_switch)
    else $error("switch test run in input-clock mode");

  property p_icm_drive;
    (inputClockMode && pulseTestEnable && !timerBusy && !off_reg)
      |=> outDrive == 4'hF;
  endproperty
  a_icm_drive: assert property (p_icm_drive)
    else $error("outputs not all on in input-clock mode");

  property p_gap_wait;
    (state_reg == SEQ_GAP && state_next == SEQ_PULSE)
      |-> gapQ_reg >= intervalQ;
  endproperty
  a_gap_wait: assert property (p_gap_wait)
    else $error("next test before interval b");

  property p_first_fail;
    (err_reg == 8'h00 && diagDone && diagFail && !memTestFail && !off_reg)
      |=> ##1 !switchOff;
  endproperty
  a_first_fail: assert property (p_first_fail)
    else $error("first failure switched outputs off");

  property p_trip;
    err_reg >= `OTPS_ERR_THRESHOLD |=> switchOff ##1 outDrive == 4'h0;
  endproperty
  a_trip: assert property (p_trip)
    else $error("threshold reached without switch-off");

  property p_violation;
    (violationEvent && viol_reg != 16'hFFFF)
      |=> viol_reg == $past(viol_reg) + 16'h0001;
  endproperty
  a_violation: assert property (p_violation)
    else $error("violation not counted");
endmodule

/* File: dv/otps_actuator_model.sv */
// Purpose: Readback model of the loads on one group of four safe outputs
// Assumes: The application requests all outputs on while tests run
// Notes:   Short low phases are reported as borderline pulse lengths
module otps_actuator_model #(
  parameter int VIOL_CYC = 30
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Output pins and fault control
  input wire logic [3:0] outDrive,
  input wire logic stuckOn,
  // Verdicts back to the sequencer
  output logic diagDone,
  output logic diagFail,
  output logic violationEvent
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed;
  int lowCnt;
  logic risen;
  // ==========================================================
  // Readback
  assign risen = armed && outDrive == 4'hF && lowCnt > 0;
  // Armed only once all outputs were on, so power-up gives no verdict
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
      lowCnt <= 0;
      diagDone <= 1'b0;
      diagFail <= 1'b0;
      violationEvent <= 1'b0;
    end else begin
      armed <= armed | (outDrive == 4'hF);
      lowCnt <= (outDrive == 4'hF) ? 0 : lowCnt + 1;
      diagDone <= risen;
      diagFail <= stuckOn;  // A welded contact still reads back high
      violationEvent <= risen && lowCnt < VIOL_CYC;
    end
  end
endmodule

/* File: dv/output_test_pulse_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the output test pulse sequencer
// Assumes: Shortened pulse base of 40 cycles, low floor of 20 cycles
// Notes:   One logic tick per clock keeps interval b near 378 cycles
module output_test_pulse_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import otps_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic configLoad = 1'b0;
  logic factorWrite = 1'b0;
  logic [3:0] pulseLengthFactor = 4'h0;
  logic [7:0] diagRepeatModulo = 8'h00;
  logic pulseTestEnable = 1'b0;
  logic inputClockMode = 1'b0;
  logic logicTick = 1'b1;
  logic [3:0] outRequest = 4'hF;
  logic memTestFail = 1'b0;
  logic stuckOn = 1'b0;
  logic halfTick = 1'b0;
  logic diagDone, diagFail, violationEvent, testActive, switchOff;
  logic [3:0] outDrive, factorOut, drv;
  logic [7:0] errorCount;
  logic [15:0] violationCount;
  otps_step_t testStep, st;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  int len, gap;
  // ==========================================================
  // Clock, timeout and instances
  always #12.5 core_clk = ~core_clk;
  // Half-rate logic tick on request, so the gap must follow the tick
  always @(posedge core_clk) begin
    if (halfTick) #1 logicTick = ~logicTick;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  otps_sequencer #(.BASE_PULSE_CYC(40), .MIN_LOW_CYC(20)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .configLoad(configLoad),
    .factorWrite(factorWrite), .pulseLengthFactor(pulseLengthFactor),
    .diagRepeatModulo(diagRepeatModulo), .pulseTestEnable(pulseTestEnable),
    .inputClockMode(inputClockMode), .logicTick(logicTick),
    .outRequest(outRequest), .diagDone(diagDone), .diagFail(diagFail),
    .violationEvent(violationEvent), .memTestFail(memTestFail),
    .outDrive(outDrive), .factorOut(factorOut), .testStep(testStep),
    .testActive(testActive), .switchOff(switchOff),
    .errorCount(errorCount), .violationCount(violationCount));
  otps_actuator_model #(.VIOL_CYC(30)) u_load (
    .core_clk(core_clk), .arst_n(arst_n), .outDrive(outDrive),
    .stuckOn(stuckOn), .diagDone(diagDone), .diagFail(diagFail),
    .violationEvent(violationEvent));
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    halfTick = 1'b0;
    pulseTestEnable = 1'b0;
    inputClockMode = 1'b0;
    stuckOn = 1'b0;
    outRequest = 4'hF;
    diagRepeatModulo = 8'h00;
    step(6);
    logicTick = 1'b1;
    arst_n = 1'b1;
    step(1);
  endtask
  task automatic set_factor(input logic [3:0] f, input logic load);
    pulseLengthFactor = f;
    factorWrite = 1'b1;
    configLoad = load;
    step(1);
    factorWrite = 1'b0;
    configLoad = 1'b0;
    step(1);
  endtask
  // Gap counts low cycles before the pulse, len the high ones
  task automatic pulse();
    gap = 0;
    len = 0;
    while (testActive !== 1'b1 && gap < 2000) begin
      step(1);
      gap++;
    end
    st = testStep;
    while (testActive === 1'b1 && len < 2000) begin
      step(1);
      len++;
      if (len == 3) drv = outDrive;
    end
  endtask
  // Interval b in ticks: quarter ticks are 20 per module cycle
  function automatic int bticks(input int m);
    return (6 * (4 + 4 * (m + 1)) * 20 + 500 + 50 + 3) / 4;
  endfunction
  task automatic run(input int s0, n, stride, lenExp, ticks);
    int e;
    for (int k = 0; k < n; k++) begin
      e = (s0 + k * stride) % 8;
      pulse();
      check(st, e);
      check(len, lenExp);
      check(drv, e[0] ? 4'h0 : 4'(~(4'h1 << e[2:1])));
      if (k > 0) check(gap >= ticks && gap <= ticks + 4, 1);
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    do_reset();
    check(factorOut, 2);
    check(errorCount, 0);
    set_factor(4'h3, 1'b0);
    check(factorOut, 3);
    set_factor(4'h5, 1'b1);
    check(factorOut, 2);
    step(60);
    check(testActive, 0);
    check(outDrive, 4'hF);
    set_factor(4'h1, 1'b0);
    pulseTestEnable = 1'b1;
    run(0, 9, 1, 40, bticks(0));
    diagRepeatModulo = 8'h01;
    run(1, 2, 1, 40, bticks(1));
    set_factor(4'h0, 1'b0);
    run(3, 1, 1, 20, 0);
    step(8);
    check(violationCount, 1);
    set_factor(4'h9, 1'b1);
    run(4, 2, 1, 80, bticks(1));
    check(errorCount, 0);
    do_reset();
    outRequest = 4'h0;
    set_factor(4'h1, 1'b0);
    pulseTestEnable = 1'b1;
    inputClockMode = 1'b1;
    halfTick = 1'b1;
    run(0, 5, 2, 40, 2 * bticks(0));
    step(2);
    check(outDrive, 4'hF);
    do_reset();
    set_factor(4'h1, 1'b0);
    stuckOn = 1'b1;
    pulseTestEnable = 1'b1;
    run(0, 3, 1, 40, bticks(0));
    step(8);
    check(errorCount, 12);
    check(switchOff, 0);
    stuckOn = 1'b0;
    run(3, 1, 1, 40, 0);
    step(8);
    check(errorCount, 11);
    stuckOn = 1'b1;
    run(4, 2, 1, 40, bticks(0));
    step(8);
    check(switchOff, 1);
    check(outDrive, 4'h0);
    do_reset();
    memTestFail = 1'b1;
    step(1);
    memTestFail = 1'b0;
    step(3);
    check(switchOff, 1);
    check(outDrive, 4'h0);
    complete_run();
  end
endmodule
